// ---- verilog/spi_mram_command_protection.sv ----
// serial memory slave: opcodes, status register, write protection
// assumes pins arrive asynchronously and the serial clock is much
// slower than clk_in (at least four clk_in cycles per half period)
`timescale 1ns/1ps
`include "spi_mram_params.svh"

module spi_mram_command_protection
  import spi_mram_pkg::*;
#(
  parameter int AW = `ADDR_WIDTH
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  input  wire logic       si_in,
  input  wire logic       wp_n_in,
  output logic            so_out,
  output logic            so_oe_out,
  output logic [7:0]      status_out,
  output logic            asleep_out,
  output logic            wbuf_ready_out
);
  // refuse widths that the address shifter and protect decode cannot serve
  if (AW < 9 || AW > 24) begin : g_bad_width
    $error("address width must lie between 9 and 24");
  end

  typedef struct packed {
    logic [3:0]    cs_m;     // first sync stage: cs, sck, si, wp
    logic [3:0]    pin;      // second sync stage
    logic          sck_d;
    logic          cs_d;
    phase_t        ph;
    logic [7:0]    op;
    logic [7:0]    sh;
    logic [2:0]    bits;
    logic [2:0]    nbytes;
    logic [AW-1:0] addr;
    logic [7:0]    status;
    logic          asleep;
    logic [7:0]    tx;
    logic          so;
    logic          so_oe;
    logic          rd_req;
    logic          rd_load;
    logic [AW+7:0] f0;
    logic [AW+7:0] f1;
    logic [1:0]    fcnt;
    logic          wready;
  } state_t;

  // nonvolatile status bits start at the factory value only once
  state_t s = '0;
  state_t next_s;

  logic [7:0] mem [2**AW];
  logic [7:0] mem_q;

  logic cs_q, sck_q, si_q, wp_q;
  logic rise, fall, cs_end, byte_done, push, pop, sw_apply;
  logic [7:0] nb;

  assign cs_q  = s.pin[3];
  assign sck_q = s.pin[2];
  assign si_q  = s.pin[1];
  assign wp_q  = s.pin[0];

  function automatic logic prot(input logic [AW-1:0] a,
                                input logic [1:0] bp);
    unique case (bp)
      2'b00: prot = 1'b0;
      2'b01: prot = &a[AW-1:AW-2];
      2'b10: prot = a[AW-1];
      2'b11: prot = 1'b1;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    next_s.cs_m = {cs_n_in, sck_in, si_in, wp_n_in};
    next_s.pin = s.cs_m;
    next_s.sck_d = sck_q;
    next_s.cs_d = cs_q;
    // mode 3 idles high, so no rise is seen at select; only edges count
    rise = ~cs_q & sck_q & ~s.sck_d;
    fall = ~cs_q & ~sck_q & s.sck_d;
    cs_end = cs_q & ~s.cs_d;
    nb = {s.sh[6:0], si_q};
    byte_done = rise && s.bits == 3'h7;
    push = 1'b0;
    sw_apply = 1'b0;
    next_s.rd_req = 1'b0;
    next_s.rd_load = s.rd_req;
    if (s.rd_load) begin
      next_s.tx = mem_q;
      next_s.addr = s.addr + 1'b1;
    end
    if (~cs_q && s.cs_d) begin
      next_s.ph = PH_OPCODE;
      next_s.bits = '0;
      next_s.nbytes = '0;
    end
    if (rise) begin
      next_s.sh = nb;
      next_s.bits = s.bits + 3'h1;
    end
    if (byte_done) begin
      if (s.nbytes != 3'h7) begin
        next_s.nbytes = s.nbytes + 3'h1;
      end
      unique case (s.ph)
        PH_OPCODE: begin
          next_s.op = nb;
          next_s.ph = PH_IGNORE;
          if (s.asleep) begin
            if (nb != `OPC_WAKE) begin
              next_s.op = 8'h00;
            end
          end else if (nb == `OPC_STATUS_READ) begin
            next_s.ph = PH_SREAD;
            next_s.tx = s.status;
          end else if (nb == `OPC_STATUS_WRITE) begin
            next_s.ph = PH_SWRITE;
          end else if (nb == `OPC_ARRAY_READ ||
                       nb == `OPC_ARRAY_WRITE) begin
            next_s.ph = PH_ADDR;
          end
        end
        PH_ADDR: begin
          // only the low AW bits of the 24-bit address survive
          next_s.addr = {s.addr[AW-9:0], nb};
          if (s.nbytes == `ADDR_BYTES - 3'h1) begin
            if (s.op == `OPC_ARRAY_READ) begin
              next_s.ph = PH_RDATA;
              next_s.rd_req = 1'b1;
            end else begin
              next_s.ph = PH_WDATA;
            end
          end
        end
        PH_RDATA: next_s.rd_req = 1'b1;
        PH_SREAD: next_s.tx = s.status;
        PH_SWRITE: begin
          // lock plus low pin freezes all but the latch bit, which the latch opcodes still change
          if (s.nbytes == 3'h1 && s.status[`ST_WEL_BIT] &&
              (!s.status[`ST_LOCK_BIT] || wp_q)) begin
            sw_apply = 1'b1;
            next_s.status = (nb & ~`ST_VOLATILE_MASK) |
                            (s.status & `ST_VOLATILE_MASK);
          end
        end
        PH_WDATA: begin
          push = s.status[`ST_WEL_BIT] &&
                 !prot(s.addr, s.status[`ST_BP_HIGH_BIT:`ST_BP_LOW_BIT]);
          next_s.addr = s.addr + 1'b1;
        end
        default: ;
      endcase
    end
    if (fall && (s.ph == PH_SREAD || s.ph == PH_RDATA)) begin
      next_s.so = s.tx[~s.bits];
      next_s.so_oe = 1'b1;
    end
    if (cs_end) begin
      next_s.ph = PH_IDLE;
      next_s.so_oe = 1'b0;
      next_s.so = 1'b0;
      if (s.nbytes == 3'h1 && s.bits == 3'h0) begin
        unique case (s.op)
          `OPC_LATCH_SET: next_s.status[`ST_WEL_BIT] = 1'b1;
          `OPC_LATCH_CLEAR: next_s.status[`ST_WEL_BIT] = 1'b0;
          `OPC_SLEEP: next_s.asleep = 1'b1;
          `OPC_WAKE: next_s.asleep = 1'b0;
          default: ;
        endcase
      end
    end
    // reads own the single memory port; queued writes wait a cycle
    pop = s.fcnt != 2'h0 && !s.rd_req;
    if (pop) begin
      next_s.f0 = s.f1;
    end
    if (push && s.wready) begin
      if (s.fcnt == 2'h0 || (s.fcnt == 2'h1 && pop)) begin
        next_s.f0 = {s.addr, nb};
      end else begin
        next_s.f1 = {s.addr, nb};
      end
    end
    next_s.fcnt = s.fcnt + {1'b0, push && s.wready} - {1'b0, pop};
    next_s.wready = next_s.fcnt != 2'h2;
    if (rst_in) begin
      next_s = '0;
      next_s.wready = 1'b1;
      // power loss clears the latch and sleep, keeps the other status bits
      next_s.status = s.status & ~`ST_VOLATILE_MASK;
      // pin stages keep tracking, so release shows no false select edge
      next_s.cs_m = {cs_n_in, sck_in, si_in, wp_n_in};
      next_s.pin = s.cs_m;
      next_s.sck_d = sck_q;
      next_s.cs_d = cs_q;
    end
  end

  always_ff @(posedge clk_in) begin
    s <= next_s;
  end

  always_ff @(posedge clk_in) begin
    if (s.rd_req) begin
      mem_q <= mem[s.addr];
    end
    if (pop) begin
      mem[s.f0[AW+7:8]] <= s.f0[7:0];
    end
  end

  assign so_out = s.so;
  assign so_oe_out = s.so_oe;
  assign status_out = s.status;
  assign asleep_out = s.asleep;
  assign wbuf_ready_out = s.wready;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_latch_set_cmd: assert property (cs_end && s.nbytes == 3'h1 &&
    s.bits == 3'h0 && s.op == `OPC_LATCH_SET |=> s.status[1])
    else $error("latch not set by latch-set opcode");
  a_latch_clear_cmd: assert property (cs_end && s.nbytes == 3'h1 &&
    s.bits == 3'h0 && s.op == `OPC_LATCH_CLEAR |=> !s.status[1])
    else $error("latch not cleared by latch-clear opcode");
  a_latch_power_up: assert property (@(posedge clk_in) disable iff (1'b0)
    rst_in |=> !s.status[1] && !s.asleep)
    else $error("latch or sleep survived power-up");
  // watch the memory port itself, not the push that was built to obey
  a_write_needs_latch: assert property (pop |-> s.status[1])
    else $error("array write stored with latch clear");
  a_protected_drop: assert property (pop |->
    !prot(s.f0[AW+7:8], s.status[3:2]))
    else $error("protected byte stored");
  a_status_locked: assert property (s.status[7] && !wp_q &&
    !cs_end |=> s.status[7:2] == $past(s.status[7:2]))
    else $error("locked status register changed");
  a_bit_zero_kept: assert property (!sw_apply |=>
    s.status[0] == $past(s.status[0]))
    else $error("status bit zero changed without a write");
  a_sleep_only_wake: assert property (s.asleep && cs_end &&
    s.op != `OPC_WAKE |=> s.asleep)
    else $error("sleep left by other than wake");
  a_read_wrap: assert property (s.rd_load && &s.addr |=>
    s.addr == '0)
    else $error("read address failed to wrap");
  a_read_fetch: assert property (s.rd_req |=> s.rd_load ##1
    s.tx == $past(mem_q))
    else $error("fetched byte not loaded");
  a_status_apply: assert property (sw_apply |=>
    (s.status & ~`ST_VOLATILE_MASK) == ($past(nb) & ~`ST_VOLATILE_MASK))
    else $error("status byte not applied");
  a_sleep_entry: assert property (cs_end && s.nbytes == 3'h1 &&
    s.bits == 3'h0 && s.op == `OPC_SLEEP |=> s.asleep)
    else $error("sleep opcode did not enter sleep");
  a_wake_exit: assert property (cs_end && s.nbytes == 3'h1 &&
    s.bits == 3'h0 && s.op == `OPC_WAKE |=> !s.asleep)
    else $error("wake opcode did not leave sleep");
  // a deselected memory must leave the output line to other devices
  a_release_quiet: assert property (cs_end |=> !s.so_oe)
    else $error("serial output still driven after deselect");

  c_status_write: cover property (sw_apply);
  c_read_wrap: cover property (s.rd_load && &s.addr);
  c_sleep_wake: cover property (s.asleep ##[1:1000] !s.asleep);
  c_buffer_full: cover property (s.fcnt == 2'h2);
  c_mode3_frame: cover property (~cs_q && s.cs_d && sck_q);
endmodule // spi_mram_command_protection

// ---- verilog/spi_mram_params.svh ----
// constants for the serial memory command and protection block
// included by the package and the block; holds definitions only
`ifndef SPI_MRAM_PARAMS_SVH
`define SPI_MRAM_PARAMS_SVH
`define OPC_LATCH_SET    8'h06
`define OPC_LATCH_CLEAR  8'h04
`define OPC_STATUS_READ  8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_ARRAY_READ   8'h03
`define OPC_ARRAY_WRITE  8'h02
`define OPC_SLEEP        8'hb9
`define OPC_WAKE         8'hab
`define ST_LOCK_BIT      7
`define ST_BP_HIGH_BIT   3
`define ST_BP_LOW_BIT    2
`define ST_WEL_BIT       1
`define ST_RESET         8'h00
`define ST_VOLATILE_MASK 8'h02
`define ADDR_BYTES       3'h4
`define ADDR_WIDTH       19
`endif

// ---- verilog/spi_mram_pkg.sv ----
// types shared by the serial memory command and protection block
// assumes the constants header sits on the include path
`include "spi_mram_params.svh"
package spi_mram_pkg;
  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR, PH_RDATA, PH_WDATA,
    PH_SREAD, PH_SWRITE, PH_IGNORE
  } phase_t;
endpackage

// ---- testbench/spi_host.sv ----
// serial host model: mode 0 or 3 frames, half period of four clk_in cycles
// assumes clk_in is the block's clock; pins change just after its edges
`timescale 1ns/1ps
module spi_host (
  input  wire logic clk_in,
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  logic last_so = 1'b0;
  logic mode3 = 1'b0;
  logic so_line;
  // a released line shows the inverse of its last level, not a stale copy
  assign so_line = so_oe_in ? so_in : ~last_so;
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end
  always @(posedge clk_in) if (so_oe_in) last_so <= so_in;
  task automatic set_mode(input logic m);
    mode3 = m;
  endtask
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // the clock settles at its idle level before select falls
  task automatic open_frame();
    sck_out = mode3;
    half();
    cs_n_out = 1'b0;
    half();
  endtask
  // sample late in the high phase so the output has settled since the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (mode3) sck_out = 1'b0;
      si_out = tx[i];
      half();
      sck_out = 1'b1;
      half();
      rx[i] = so_line;
      if (!mode3) sck_out = 1'b0;
    end
  endtask
  task automatic close_frame();
    half();
    cs_n_out = 1'b1;
    repeat (3) half();
  endtask
endmodule // spi_host

// ---- testbench/testbench.sv ----
// self-checking bench for the serial memory command and protection block
// assumes the host model drives the link; wp_n and reset come from here
`timescale 1ns/1ps
module testbench;
  logic       clk_in;
  logic       rst_in;
  logic       wp_n_in;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  logic       asleep;
  logic       wbuf_ready;
  logic [7:0] status;
  logic [7:0] r0;
  logic [7:0] r1;
  int         n_fail = 0;
  int         checked = 0;
  // clk_in cycles of deselect after wake; value arbitrary
  localparam int wake_recovery_time = 40;
  spi_mram_command_protection spi_mram_command_protection_inst (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe),
    .status_out(status), .asleep_out(asleep),
    .wbuf_ready_out(wbuf_ready));
  spi_host spi_host_inst (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
    .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input string name, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk_in);
    #1 rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic op1(input logic [7:0] op);
    logic [7:0] r;
    spi_host_inst.open_frame();
    spi_host_inst.xfer(op, r);
    spi_host_inst.close_frame();
  endtask
  task automatic op2(input logic [7:0] op, d, output logic [7:0] r);
    spi_host_inst.open_frame();
    spi_host_inst.xfer(op, r);
    spi_host_inst.xfer(d, r);
    spi_host_inst.close_frame();
  endtask
  task automatic mem(input logic [7:0] op, input logic [23:0] a,
                     input logic [7:0] d0, d1, output logic [7:0] q0, q1);
    logic [7:0] r;
    spi_host_inst.open_frame();
    spi_host_inst.xfer(op, r);
    spi_host_inst.xfer(a[23:16], r);
    spi_host_inst.xfer(a[15:8], r);
    spi_host_inst.xfer(a[7:0], r);
    spi_host_inst.xfer(d0, q0);
    spi_host_inst.xfer(d1, q1);
    spi_host_inst.close_frame();
  endtask
  task automatic t_reset();
    check("status", status, 8'h00);
    check("asleep", {7'h00, asleep}, 8'h00);
    check("so_oe", {7'h00, so_oe}, 8'h00);
    check("wbuf_ready", {7'h00, wbuf_ready}, 8'h01);
  endtask
  // upper address bits are junk on purpose; only the low 19 count
  task automatic t_latch();
    op1(8'h06);
    check("status", status, 8'h02);
    mem(8'h02, 24'h87ffff, 8'h33, 8'h44, r0, r1);
    op1(8'h04);
    check("status", status, 8'h00);
    mem(8'h02, 24'h87ffff, 8'haa, 8'hbb, r0, r1);
    mem(8'h03, 24'h07ffff, 8'h00, 8'h00, r0, r1);
    check("rd0", r0, 8'h33);
    check("rd1", r1, 8'h44);
    // the first status read after an array read is thrown away
    op2(8'h05, 8'h00, r0);
    op2(8'h05, 8'h00, r0);
    check("status_read_cmd", r0, 8'h00);
  endtask
  task automatic t_protect();
    op1(8'h06);
    op2(8'h01, 8'h04, r0);
    op2(8'h05, 8'h00, r0);
    check("status_read_cmd", r0, 8'h06);
    mem(8'h02, 24'h07ffff, 8'h55, 8'h66, r0, r1);
    mem(8'h03, 24'h07ffff, 8'h00, 8'h00, r0, r1);
    check("rd0", r0, 8'h33);
    check("rd1", r1, 8'h66);
  endtask
  // mode 3 idles the clock high; the stored bytes must come back alike
  task automatic t_mode3();
    spi_host_inst.set_mode(1'b1);
    mem(8'h03, 24'h07ffff, 8'h00, 8'h00, r0, r1);
    check("rd0_m3", r0, 8'h33);
    check("rd1_m3", r1, 8'h66);
    op1(8'h06);
    op2(8'h05, 8'h00, r0);
    check("status_read_cmd_m3", r0, 8'h06);
    spi_host_inst.set_mode(1'b0);
  endtask
  task automatic t_lock();
    op2(8'h01, 8'h84, r0);
    check("status", status, 8'h86);
    @(posedge clk_in);
    #1 wp_n_in = 1'b0;
    op2(8'h01, 8'h00, r0);
    check("status", status, 8'h86);
    @(posedge clk_in);
    #1 wp_n_in = 1'b1;
    op2(8'h01, 8'h71, r0);
    check("status", status, 8'h73);
  endtask
  task automatic t_sleep();
    op2(8'h01, 8'h08, r0);
    op1(8'hb9);
    check("asleep", {7'h00, asleep}, 8'h01);
    op1(8'h04);
    check("status", status, 8'h0a);
    op1(8'hab);
    repeat (wake_recovery_time) @(posedge clk_in);
    #1;
    check("asleep", {7'h00, asleep}, 8'h00);
    op1(8'hb9);
    do_reset();
    check("asleep", {7'h00, asleep}, 8'h00);
    check("status", status, 8'h08);
  endtask
  initial begin
    rst_in  = 1'b1;
    wp_n_in = 1'b1;
    do_reset();
    t_reset();
    t_latch();
    t_protect();
    t_mode3();
    t_lock();
    t_sleep();
    end_of_test();
  end
  // whole run needs well under half a millisecond
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule // testbench
